// File: aia_consts.svh
// Purpose: Offsets, field positions, reset values for the arithmetic ALU
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes:   Low 12 address bits are decoded; higher bits alias
`ifndef AIA_CONSTS_SVH
`define AIA_CONSTS_SVH

// Register byte offsets
`define AIA_OFF_WREG    12'h000
`define AIA_OFF_MEMB    12'h004
`define AIA_OFF_IMM     12'h008
`define AIA_OFF_FLAGS   12'h00C
`define AIA_OFF_CMD     12'h010

// Decoded address width
`define AIA_ADDR_W      12

// Flag bit positions inside the flag register
`define AIA_FLAG_Z      0
`define AIA_FLAG_C      1
`define AIA_FLAG_AC     2
`define AIA_FLAG_OV     3

// Reset values
`define AIA_BYTE_RST    8'h00
`define AIA_FLAGS_RST   4'h0
`define AIA_OP_RST      4'h0
`define AIA_RDATA_RST   32'h0000_0000

// Bus encodings
`define AIA_HTRANS_SEL  1
`define AIA_HRESP_OKAY  1'b0

`endif

// File: aia_pkg.sv
// Purpose: Types shared by the arithmetic ALU files
// Assumes: Nothing beyond SystemVerilog packages
// Notes:   Opcode codes are the values software writes to the command word
package aia_pkg;

    // Arithmetic command codes
    typedef enum logic [3:0] {
        AIA_ADD_AI  = 4'b0000,
        AIA_ADD_AM  = 4'b0001,
        AIA_ADD_MA  = 4'b0010,
        AIA_ADDC_AM = 4'b0011,
        AIA_ADDC_MA = 4'b0100,
        AIA_ADDC_A  = 4'b0101,
        AIA_ADDC_M  = 4'b0110,
        AIA_SUB_AI  = 4'b0111,
        AIA_SUB_AM  = 4'b1000,
        AIA_SUB_MA  = 4'b1001,
        AIA_SUBC_AM = 4'b1010,
        AIA_SUBC_MA = 4'b1011,
        AIA_SUBC_A  = 4'b1100,
        AIA_SUBC_M  = 4'b1101
    } aia_op_t;

    // Bus slave states
    typedef enum logic [1:0] {
        AIA_BUS_IDLE = 2'b00,
        AIA_BUS_WAIT = 2'b01
    } aia_bus_state_t;

endpackage

// File: aia_adder.sv
// Purpose: Eight-bit adder with two's complement subtract and flags
// Assumes: Purely combinational, registered by the caller
// Notes:   Subtract adds the inverted operand plus inverted carry-in
`timescale 1ns/10ps
module aia_adder (
    input  wire logic [7:0] x_i,
    input  wire logic [7:0] y_i,
    input  wire logic       ci_i,
    input  wire logic       sub_i,
    output logic      [7:0] sum_o,
    output logic            zero_o,
    output logic            carry_o,
    output logic            nib_o,
    output logic            wrap_o
);
    logic [7:0] yy;
    logic       cc;
    logic [8:0] full;
    logic [4:0] low;

    // Operand conditioning and sum; carry out past bit 7 kept apart
    always_comb begin
        yy      = sub_i ? ~y_i : y_i;
        cc      = ci_i ^ sub_i;
        full    = {1'b0, x_i} + {1'b0, yy} + {8'h00, cc};
        low     = {1'b0, x_i[3:0]} + {1'b0, yy[3:0]} + {4'h0, cc};
        sum_o   = full[7:0];
        zero_o  = (full[7:0] == 8'h00);
        carry_o = full[8] ^ sub_i;
        nib_o   = low[4] ^ sub_i;
        wrap_o  = (x_i[7] == yy[7]) && (full[7] != x_i[7]);
    end
endmodule

// File: aia_top.sv
// Purpose: Add/subtract instruction datapath behind an AHB-Lite slave
// Assumes: One master, word transfers, bus signals on clk_i
// Notes:   Writing the command word runs the operation at once
//
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "aia_consts.svh"
module aia_top (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic      [7:0]  working_register_o,
    output logic      [7:0]  mem_byte_o,
    output logic      [3:0]  flags_o,
    output logic             mem_wr_o
);
    import aia_pkg::*;

    aia_bus_state_t            state;
    aia_bus_state_t            next_state;
    logic [`AIA_ADDR_W-1:0]    addr_q;
    logic [`AIA_ADDR_W-1:0]    next_addr_q;
    logic                      wr_q;
    logic                      next_wr_q;
    logic [7:0]                wreg;
    logic [7:0]                next_wreg;
    logic [7:0]                memb;
    logic [7:0]                next_memb;
    logic [7:0]                imm;
    logic [7:0]                next_imm;
    logic [3:0]                flags;
    logic [3:0]                next_flags;
    logic [3:0]                last_op;
    logic [3:0]                next_last_op;
    logic [31:0]               hrdata;
    logic [31:0]               next_hrdata;
    logic                      hready;
    logic                      next_hready;
    logic                      mem_wr;
    logic                      next_mem_wr;

    logic                      accept;
    logic                      exec_go;
    aia_op_t                   exec_op;
    logic [7:0]                alu_x;
    logic [7:0]                alu_y;
    logic                      alu_ci;
    logic                      alu_sub;
    logic                      dest_mem;
    logic                      op_ok;
    logic [7:0]                alu_sum;
    logic                      alu_zero;
    logic                      alu_carry;
    logic                      alu_nib;
    logic                      alu_wrap;

    // Register readback, narrow values zero-extended, unmapped reads zero
    function automatic logic [31:0] read_word(
        input logic [`AIA_ADDR_W-1:0] a,
        input logic [7:0]             w, m, i,
        input logic [3:0]             f, o
    );
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            `AIA_OFF_WREG:  r = {24'h00_0000, w};
            `AIA_OFF_MEMB:  r = {24'h00_0000, m};
            `AIA_OFF_IMM:   r = {24'h00_0000, i};
            `AIA_OFF_FLAGS: r = {28'h000_0000, f};
            `AIA_OFF_CMD:   r = {28'h000_0000, o};
            default:        r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // Address phase qualifier and command-launch strobe
    assign accept  = hsel_i && hready_i && htrans_i[`AIA_HTRANS_SEL];
    assign exec_go = (state == AIA_BUS_WAIT) && wr_q &&
                     (addr_q == `AIA_OFF_CMD);
    assign exec_op = aia_op_t'(hwdata_i[3:0]);

    // Operand routing per command
    always_comb begin
        alu_x    = wreg;
        alu_y    = 8'h00;
        alu_ci   = 1'b0;
        alu_sub  = 1'b0;
        dest_mem = 1'b0;
        op_ok    = 1'b1;
        case (exec_op)
            AIA_ADD_AI:  alu_y = imm;
            AIA_ADD_AM:  alu_y = memb;
            AIA_ADD_MA: begin
                alu_y    = memb;
                dest_mem = 1'b1;
            end
            AIA_ADDC_AM: begin
                alu_y  = memb;
                alu_ci = flags[`AIA_FLAG_C];
            end
            AIA_ADDC_MA: begin
                alu_y    = memb;
                alu_ci   = flags[`AIA_FLAG_C];
                dest_mem = 1'b1;
            end
            AIA_ADDC_A:  alu_ci = flags[`AIA_FLAG_C];
            AIA_ADDC_M: begin
                alu_x    = memb;
                alu_ci   = flags[`AIA_FLAG_C];
                dest_mem = 1'b1;
            end
            AIA_SUB_AI: begin
                alu_y   = imm;
                alu_sub = 1'b1;
            end
            AIA_SUB_AM: begin
                alu_y   = memb;
                alu_sub = 1'b1;
            end
            AIA_SUB_MA: begin
                alu_x    = memb;
                alu_y    = wreg;
                alu_sub  = 1'b1;
                dest_mem = 1'b1;
            end
            AIA_SUBC_AM: begin
                alu_y   = memb;
                alu_ci  = flags[`AIA_FLAG_C];
                alu_sub = 1'b1;
            end
            AIA_SUBC_MA: begin
                alu_x    = memb;
                alu_y    = wreg;
                alu_ci   = flags[`AIA_FLAG_C];
                alu_sub  = 1'b1;
                dest_mem = 1'b1;
            end
            AIA_SUBC_A: begin
                alu_ci  = flags[`AIA_FLAG_C];
                alu_sub = 1'b1;
            end
            AIA_SUBC_M: begin
                alu_x    = memb;
                alu_ci   = flags[`AIA_FLAG_C];
                alu_sub  = 1'b1;
                dest_mem = 1'b1;
            end
            default:     op_ok = 1'b0;  // Undefined code runs nothing
        endcase
    end

    // Shared adder
    aia_adder u_adder (
        .x_i     (alu_x),
        .y_i     (alu_y),
        .ci_i    (alu_ci),
        .sub_i   (alu_sub),
        .sum_o   (alu_sum),
        .zero_o  (alu_zero),
        .carry_o (alu_carry),
        .nib_o   (alu_nib),
        .wrap_o  (alu_wrap)
    );

    // Bus slave and register file next values
    always_comb begin
        next_state   = state;
        next_addr_q  = addr_q;
        next_wr_q    = wr_q;
        next_wreg    = wreg;
        next_memb    = memb;
        next_imm     = imm;
        next_flags   = flags;
        next_last_op = last_op;
        next_hrdata  = hrdata;
        next_hready  = hready;
        next_mem_wr  = 1'b0;
        case (state)
            AIA_BUS_IDLE: begin
                if (accept) begin
                    next_state  = AIA_BUS_WAIT;
                    next_addr_q = haddr_i[`AIA_ADDR_W-1:0];
                    next_wr_q   = hwrite_i;
                    next_hready = 1'b0;
                end
            end
            AIA_BUS_WAIT: begin
                next_state  = AIA_BUS_IDLE;
                next_hready = 1'b1;
                if (!wr_q) begin
                    next_hrdata = read_word(addr_q, wreg, memb, imm,
                                            flags, last_op);
                end else begin
                    case (addr_q)
                        `AIA_OFF_WREG:  next_wreg  = hwdata_i[7:0];
                        `AIA_OFF_MEMB:  next_memb  = hwdata_i[7:0];
                        `AIA_OFF_IMM:   next_imm   = hwdata_i[7:0];
                        `AIA_OFF_FLAGS: next_flags = hwdata_i[3:0];
                        `AIA_OFF_CMD: begin
                            next_last_op = hwdata_i[3:0];
                            if (op_ok) begin
                                next_flags[`AIA_FLAG_Z] = alu_zero;
                                next_flags[`AIA_FLAG_C] = alu_carry;
                                next_flags[`AIA_FLAG_AC] = alu_nib;
                                next_flags[`AIA_FLAG_OV] = alu_wrap;
                                if (dest_mem) begin
                                    next_memb   = alu_sum;
                                    next_mem_wr = 1'b1;
                                end else begin
                                    next_wreg = alu_sum;
                                end
                            end
                        end
                        default: next_wreg = wreg;  // Unmapped write ignored
                    endcase
                end
            end
            default: begin
                next_state  = AIA_BUS_IDLE;
                next_hready = 1'b1;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state   <= AIA_BUS_IDLE;
            addr_q  <= `AIA_OFF_WREG;
            wr_q    <= 1'b0;
            wreg    <= `AIA_BYTE_RST;
            memb    <= `AIA_BYTE_RST;
            imm     <= `AIA_BYTE_RST;
            flags   <= `AIA_FLAGS_RST;
            last_op <= `AIA_OP_RST;
            hrdata  <= `AIA_RDATA_RST;
            hready  <= 1'b1;
            mem_wr  <= 1'b0;
        end else begin
            state   <= next_state;
            addr_q  <= next_addr_q;
            wr_q    <= next_wr_q;
            wreg    <= next_wreg;
            memb    <= next_memb;
            imm     <= next_imm;
            flags   <= next_flags;
            last_op <= next_last_op;
            hrdata  <= next_hrdata;
            hready  <= next_hready;
            mem_wr  <= next_mem_wr;
        end
    end

    // Outputs straight from flops, hresp_o tied to OKAY
    assign hrdata_o           = hrdata;
    assign hreadyout_o        = hready;
    assign hresp_o            = `AIA_HRESP_OKAY;
    assign working_register_o = wreg;
    assign mem_byte_o         = memb;
    assign flags_o            = flags;
    assign mem_wr_o           = mem_wr;

    // Checks on the datapath
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_exec(aia_op_t op);
        exec_go && (exec_op == op);
    endsequence

    AST_ADD_IMM: assert property (s_exec(AIA_ADD_AI) |=>
        wreg == $past(wreg) + $past(imm))
        else $error("add immediate result wrong");
    AST_ADD_MEM_CARRY: assert property (s_exec(AIA_ADD_AM) |=>
        {flags[`AIA_FLAG_C], wreg} == {1'b0, $past(wreg)} + $past(memb))
        else $error("add memory sum or carry wrong");
    AST_ADD_TO_MEM: assert property (s_exec(AIA_ADD_MA) |=>
        memb == $past(wreg) + $past(memb) && $stable(wreg) && mem_wr)
        else $error("add to memory wrong");
    AST_ADDC_REG: assert property (s_exec(AIA_ADDC_AM) |=>
        wreg == $past(wreg) + $past(memb) + $past(flags[`AIA_FLAG_C]))
        else $error("add with carry to register wrong");
    AST_ADDC_ONE: assert property (s_exec(AIA_ADDC_M) |=>
        memb == $past(memb) + $past(flags[`AIA_FLAG_C]))
        else $error("memory plus carry wrong");
    AST_SUB_BORROW: assert property (s_exec(AIA_SUB_AM) |=>
        wreg == $past(wreg) - $past(memb) &&
        flags[`AIA_FLAG_C] == ($past(wreg) < $past(memb)) &&
        flags[`AIA_FLAG_AC] == ($past(wreg[3:0]) < $past(memb[3:0])))
        else $error("subtract memory or borrow wrong");
    AST_SUB_TO_MEM: assert property (s_exec(AIA_SUB_MA) |=>
        memb == $past(memb) - $past(wreg) ##1 !mem_wr)
        else $error("memory minus register wrong");
    AST_SUBC_MEM: assert property (s_exec(AIA_SUBC_MA) |=>
        memb == $past(memb) - $past(wreg) - $past(flags[`AIA_FLAG_C]))
        else $error("subtract with carry into memory wrong");
    AST_SUBC_ONE: assert property (s_exec(AIA_SUBC_A) |=>
        wreg == $past(wreg) - $past(flags[`AIA_FLAG_C]))
        else $error("register minus carry wrong");
    AST_WRAP: assert property (s_exec(AIA_ADD_AI) |=>
        flags[`AIA_FLAG_OV] == ($past(wreg[7]) == $past(imm[7]) &&
                               wreg[7] != $past(wreg[7])))
        else $error("signed wrap flag wrong");
    AST_ZERO: assert property (exec_go && op_ok |=>
        flags[`AIA_FLAG_Z] == (($past(dest_mem) ? memb : wreg) == 8'h00))
        else $error("zero flag wrong");
    AST_BAD_OP: assert property (exec_go && !op_ok |=>
        $stable(wreg) && $stable(memb) && $stable(flags))
        else $error("undefined command changed state");
    AST_WAIT_STATE: assert property (accept && state == AIA_BUS_IDLE |=>
        !hreadyout_o ##1 hreadyout_o)
        else $error("data phase length wrong");
endmodule

// File: aia_mem_model.sv
// Purpose: Data memory stand-in at the far side of the arithmetic ALU
// Assumes: A memory byte write arrives as a one-cycle mem_wr_i pulse
// Notes:   Keeps the last byte written and a count of write pulses
`timescale 1ns/10ps
module aia_mem_model (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        mem_wr_i,
    input  wire logic [7:0]  mem_byte_i,
    output logic      [7:0]  stored_o,
    output logic      [15:0] count_o
);
    logic [7:0]  next_stored;
    logic [15:0] next_count;

    // Take the byte on each write pulse
    always_comb begin
        next_stored = stored_o;
        next_count  = count_o;
        if (mem_wr_i) begin
            next_stored = mem_byte_i;
            next_count  = count_o + 16'h0001;
        end
    end

    // Register the memory state
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            stored_o <= 8'h00;
            count_o  <= 16'h0000;
        end else begin
            stored_o <= next_stored;
            count_o  <= next_count;
        end
    end
endmodule

// File: tb_arith_instruction_alu.sv
// Purpose: Self-checking bench for the arithmetic ALU
// Assumes: One AHB-Lite master, hready fed back from hreadyout
// Notes:   Random operands from xorshift plus fixed corner values
`timescale 1ns/10ps
`include "aia_consts.svh"
module tb_arith_instruction_alu;
    import aia_pkg::*;
    logic        clk_i, resetn_i, hsel_i, hwrite_i, hreadyout_o;
    logic        hresp_o, mem_wr_o;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, rd, got, exp_v;
    logic [1:0]  htrans_i;
    logic [2:0]  hsize_i;
    logic [7:0]  working_register_o, mem_byte_o, stored, w, m, i, eb;
    logic [3:0]  flags_o, f, lf;
    logic [15:0] count, ecnt;
    logic [12:0] e;
    logic [31:0] seed;
    int          errors, total_checks;
    logic [7:0]  cw[5] = '{8'hFF, 8'h7F, 8'h80, 8'h00, 8'h0F};
    logic [7:0]  cm[5] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'hF1};
    logic [7:0]  cim[5] = '{8'h01, 8'h7F, 8'h80, 8'h00, 8'hF1};
    logic [3:0]  cf[5] = '{4'h0, 4'h0, 4'hF, 4'h2, 4'h2};

    aia_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .working_register_o(working_register_o), .mem_byte_o(mem_byte_o),
        .flags_o(flags_o), .mem_wr_o(mem_wr_o));

    aia_mem_model mem (.clk_i(clk_i), .resetn_i(resetn_i),
        .mem_wr_i(mem_wr_o), .mem_byte_i(mem_byte_o), .stored_o(stored),
        .count_o(count));

    // Free-running 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Next pseudo-random word
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected {dest is memory, ov, ac, c, z, result}
    function automatic logic [12:0] ref_op(input logic [3:0] op,
        input logic [7:0] w, input logic [7:0] m, input logic [7:0] i,
        input logic c);
        logic       sub, dm, uc, ci;
        logic [7:0] x, y, r;
        logic [8:0] s;
        logic [4:0] n;
        sub = (op >= AIA_SUB_AI);
        dm  = op inside {AIA_ADD_MA, AIA_ADDC_MA, AIA_ADDC_M, AIA_SUB_MA,
                         AIA_SUBC_MA, AIA_SUBC_M};
        uc  = !(op inside {AIA_ADD_AI, AIA_ADD_AM, AIA_ADD_MA, AIA_SUB_AI,
                           AIA_SUB_AM, AIA_SUB_MA});
        x   = dm ? m : w;
        y   = dm ? w : m;
        if (op == AIA_ADD_AI || op == AIA_SUB_AI) y = i;
        if (op inside {AIA_ADDC_A, AIA_ADDC_M, AIA_SUBC_A, AIA_SUBC_M})
            y = 8'h00;
        if (sub) y = ~y;
        ci = sub ^ (uc & c);
        s  = {1'b0, x} + {1'b0, y} + {8'h00, ci};
        n  = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
        r  = s[7:0];
        return {dm, (x[7] == y[7]) && (r[7] != x[7]), n[4] ^ sub,
                s[8] ^ sub, r == 8'h00, r};
    endfunction

    // Compare and count
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Wait for hready high at a rising edge, bounded
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk_i);
        while (hreadyout_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20) errors++;
    endtask

    // One single word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [11:0] a,
        input logic [31:0] wd);
        hsel_i   <= 1'b1;
        haddr_i  <= {20'h00000, a};
        htrans_i <= 2'b10;
        hwrite_i <= wr;
        wait_ready();
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        wait_ready();
        rd = hrdata_o;
    endtask

    // Read a register and compare
    task automatic rdchk(input string name, input logic [11:0] a,
        input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(name, rd, exp);
    endtask

    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (10000) @(posedge clk_i);
        errors++;
        test_done();
    end

    // Main sequence
    initial begin
        resetn_i = 1'b0;
        hsel_i = 1'b0;
        haddr_i = 32'h0000_0000;
        htrans_i = 2'b00;
        hwrite_i = 1'b0;
        hsize_i = 3'b010;
        hwdata_i = 32'h0000_0000;
        errors = 0;
        total_checks = 0;
        seed = 32'd74615;
        ecnt = 16'h0000;
        eb = 8'h00;
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        check("hresp", {31'h0, hresp_o}, 32'h0);
        for (int a = 0; a <= 20; a += 4) rdchk("reset", a[11:0], 32'h0);
        bus(1'b1, 12'h014, 32'hFFFF_FFFF);
        rdchk("unmapped", 12'h014, 32'h0);
        $display("test reset done");
        // Every command with corner and random operands
        for (int op = 0; op < 14; op++) begin
            for (int k = 0; k < 10; k++) begin
                if (k < 5) begin
                    w = cw[k];
                    m = cm[k];
                    i = cim[k];
                    f = cf[k];
                end else begin
                    w = 8'(xs());
                    m = 8'(xs());
                    i = 8'(xs());
                    f = 4'(xs());
                end
                bus(1'b1, `AIA_OFF_WREG, {24'h0, w});
                bus(1'b1, `AIA_OFF_MEMB, {24'h0, m});
                bus(1'b1, `AIA_OFF_IMM, {24'h0, i});
                bus(1'b1, `AIA_OFF_FLAGS, {28'h0, f});
                bus(1'b1, `AIA_OFF_CMD, op);
                e = ref_op(op[3:0], w, m, i, f[1]);
                got = {24'h0, e[12] ? mem_byte_o : working_register_o};
                exp_v = {24'h0, e[7:0]};
                case (op[3:0])
                    AIA_ADD_AI:  check("res", got, exp_v);
                    AIA_ADD_AM:  check("res", got, exp_v);
                    AIA_ADD_MA:  check("res", got, exp_v);
                    AIA_ADDC_AM: check("res", got, exp_v);
                    AIA_ADDC_MA: check("res", got, exp_v);
                    AIA_ADDC_A:  check("res", got, exp_v);
                    AIA_ADDC_M:  check("res", got, exp_v);
                    AIA_SUB_AI:  check("res", got, exp_v);
                    AIA_SUB_AM:  check("res", got, exp_v);
                    AIA_SUB_MA:  check("res", got, exp_v);
                    AIA_SUBC_AM: check("res", got, exp_v);
                    AIA_SUBC_MA: check("res", got, exp_v);
                    AIA_SUBC_A:  check("res", got, exp_v);
                    default:     check("res", got, exp_v);
                endcase
                exp_v = {28'h0, e[11:8]};
                check("flags", {28'h0, flags_o}, exp_v);
                exp_v = {24'h0, e[12] ? w : e[7:0]};
                rdchk("wreg", `AIA_OFF_WREG, exp_v);
                exp_v = {24'h0, e[12] ? e[7:0] : m};
                rdchk("memb", `AIA_OFF_MEMB, exp_v);
                if (e[12]) begin
                    ecnt = ecnt + 16'h0001;
                    eb = e[7:0];
                end
                check("mem count", {16'h0, count}, {16'h0, ecnt});
                check("mem byte", {24'h0, stored}, {24'h0, eb});
            end
        end
        $display("test arithmetic done");
        // Undefined command codes change nothing but the readback
        w = working_register_o;
        m = mem_byte_o;
        lf = flags_o;
        for (int c = 14; c < 16; c++) begin
            bus(1'b1, `AIA_OFF_CMD, c);
            rdchk("cmd", `AIA_OFF_CMD, c);
            check("wreg kept", {24'h0, working_register_o}, {24'h0, w});
            check("memb kept", {24'h0, mem_byte_o}, {24'h0, m});
            check("flags kept", {28'h0, flags_o}, {28'h0, lf});
            check("no mem wr", {16'h0, count}, {16'h0, ecnt});
        end
        $display("test undefined codes done");
        test_done();
    end
endmodule
